// ==== core/track_trigger.sv ====
`timescale 1ns/100ps
`default_nettype none

// What this block does
// [R01] sources send chip headers, then channel/height pairs
// [R02] subtract pedestal, drop bad channels first
// [R03] find adjacent hit strips, output cluster centroid
// [R04] merge three hit finders into one stream
// [R05] words pushed without request into receiver
// [R06] take outer tracks and merged centroids
// [R07] centroid to superstrip through loadable table
// [R08] broadcast tracks and superstrips to matchers
// [R09] hold 128 stored roads
// [R10] road with track and four hits is candidate
// [R11] road contents loadable from outside
// [R12] hit buffer stores words by superstrip
// [R13] candidates forwarded once matching completes
// [R14] road superstrips fetch full resolution data
// [R15] packet is one track plus four hits
// [R16] spread packets evenly over ten fitters
// [R17] fit is scalar products with constants
// [R18] one stream word per clock
// [R19] flag events exceeding 17 us budget
// [R20] produce azimuth, momentum and impact parameter
// [R21] hold sender before receiver overflows
module track_trigger (
    input  wire logic                      CORE_CLK,    // core clock
    input  wire logic                      RESET,       // sync reset
    input  wire trig_pkg::strip_word_t [2:0] STRIP_IN,  // strip streams
    input  wire trig_pkg::trk_word_t       TRK_IN,      // outer tracks
    input  wire logic                      EVT_END,     // event closed
    input  wire trig_pkg::load_t           LOAD,        // table loads
    output logic [2:0]                     HOLD,        // stop sending
    output trig_pkg::packet_t              PKT,         // track packet
    output logic                           PKT_VALID,   // packet strobe
    output logic [6:0]                     PKT_ROAD,    // road number
    output logic [3:0]                     FIT_SEL,     // target fitter
    output trig_pkg::fit_t                 FIT_PARAM,   // fit result
    output logic                           OVER_BUDGET  // late event
);

    // ------------------------------------------------------------
    // state and tables
    // ------------------------------------------------------------
    typedef struct packed {
        trig_pkg::strip_word_t [2:0] sy1;
        trig_pkg::strip_word_t [2:0] sy2;
        trig_pkg::trk_word_t         t1;
        trig_pkg::trk_word_t         t2;
        logic                        e1;
        logic                        e2;
        logic [3:0]                  shift;
        logic [2:0]                  odd;
        logic [2:0][7:0]             ch;
        logic [2:0][4:0]             chip;
        logic [2:0]                  open;
        logic [2:0][4:0]             cchip;
        logic [2:0][7:0]             first;
        logic [2:0][7:0]             last;
        logic [2:0][1:0]             cnt;
        logic [2:0][1:0][13:0]       q;
        logic [1:0]                  rr;
        logic [127:0][4:0]           pres;
        trig_pkg::phase_t            phase;
        logic [6:0]                  road;
        logic [3:0]                  fsel;
        logic                        act;
        logic [8:0]                  cyc;
        logic                        over;
        logic                        pv;
        logic [6:0]                  proad;
        logic [3:0]                  osel;
        trig_pkg::packet_t           pkt;
        trig_pkg::fit_t              fit;
    } state_t;

    state_t      s;
    state_t      n;
    logic [8:0]  ped   [1024];
    logic [5:0]  lut   [256];
    logic [29:0] roads [128];
    logic [13:0] hbin  [256];
    logic [13:0] tbin  [64];
    logic        gv;
    logic [1:0]  gu;
    logic        hb_we;
    logic [7:0]  hb_addr;
    logic [13:0] hb_data;
    logic        tb_we;
    logic [5:0]  tb_addr;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [8:0]              pe;
        logic                    hit;
        logic                    adj;
        logic                    em;
        logic                    flush;
        logic                    any_in;
        logic [1:0]              c;
        logic [1:0]              idx;
        logic [8:0]              span;
        logic [29:0]             rd;
        logic [4:0][13:0]        x;
        logic signed [25:0]      acc;
        n = s;
        pe = '0;
        hit = 1'b0;
        adj = 1'b0;
        em = 1'b0;
        c = '0;
        idx = '0;
        span = '0;
        rd = '0;
        x = '0;
        acc = '0;
        flush = s.e2 && s.phase == trig_pkg::PH_COLLECT;
        any_in = s.sy2[0].valid || s.sy2[1].valid || s.sy2[2].valid
                 || s.t2.valid;
        // inputs from other boards pass two flops, no request
        n.sy1 = STRIP_IN; // [R05]
        n.sy2 = s.sy1;
        n.t1 = TRK_IN;
        n.t2 = s.t1;
        n.e1 = EVT_END;
        n.e2 = s.e1;
        // superstrip granularity
        if (LOAD.we && LOAD.sel == trig_pkg::LD_SHIFT) begin
            n.shift = LOAD.data[3:0]; // [R07]
        end
        // round robin over pending clusters; tracks go first
        gv = 1'b0;
        gu = '0;
        for (int k = 2; k >= 0; k--) begin
            idx = 2'((int'(s.rr) + k) % 3);
            if (s.cnt[idx] != 2'h0) begin
                gv = 1'b1; // [R04]
                gu = idx;
            end
        end
        if (s.t2.valid || s.phase == trig_pkg::PH_SCAN) begin
            gv = 1'b0;
        end
        if (gv) begin
            n.rr = (gu == 2'h2) ? 2'h0 : gu + 2'h1;
        end
        // hit finders: pedestal, bad channels, clusters
        for (int u = 0; u < 3; u++) begin
            em = 1'b0;
            if (s.phase == trig_pkg::PH_COLLECT && s.sy2[u].valid) begin
                if (s.sy2[u].hdr) begin
                    n.chip[u] = s.sy2[u].data[4:0]; // [R01]
                end else if (!s.odd[u]) begin
                    n.ch[u] = s.sy2[u].data;
                    n.odd[u] = 1'b1;
                end else begin
                    n.odd[u] = 1'b0;
                    pe = ped[{2'(u), s.ch[u]}];
                    hit = !pe[8] && {1'b0, s.sy2[u].data}
                          >= {1'b0, pe[7:0]} + trig_pkg::HIT_THRESH; // [R02]
                    adj = s.open[u] && s.cchip[u] == s.chip[u]
                          && s.ch[u] == s.last[u] + 8'h01;
                    em = s.open[u] && !(hit && adj); // [R03]
                    if (hit && adj) begin
                        n.last[u] = s.ch[u];
                    end else if (hit) begin
                        n.first[u] = s.ch[u];
                        n.last[u] = s.ch[u];
                        n.cchip[u] = s.chip[u];
                    end
                    n.open[u] = hit;
                end
            end
            if (flush && s.open[u]) begin
                em = 1'b1;
                n.open[u] = 1'b0;
            end
            // over-wide clusters are dropped, not split
            span = {1'b0, s.first[u]} + {1'b0, s.last[u]};
            em = em && (s.last[u] - s.first[u] <= trig_pkg::MAX_WIDTH);
            c = s.cnt[u] - ((gv && gu == 2'(u)) ? 2'h1 : 2'h0);
            if (gv && gu == 2'(u)) begin
                n.q[u][0] = s.q[u][1];
            end
            if (em) begin
                n.q[u][c[0]] = {s.cchip[u], span}; // [R03]
                c = c + 2'h1;
            end
            n.cnt[u] = c;
        end
        // stage word: written to hit buffer and seen by every road
        hb_we = 1'b0;
        tb_we = 1'b0;
        hb_addr = '0;
        hb_data = '0;
        tb_addr = '0;
        if (s.t2.valid && s.phase != trig_pkg::PH_SCAN) begin
            tb_we = 1'b1; // [R06]
            tb_addr = s.t2.data[trig_pkg::TRK_SS_LSB +: 6];
        end else if (gv) begin
            hb_we = 1'b1; // [R06]
            hb_data = s.q[gu][0];
            hb_addr = {hb_data[10:9], lut[8'(hb_data >> s.shift)]}; // [R07]
        end
        for (int r = 0; r < trig_pkg::NUM_ROADS; r++) begin
            rd = roads[r]; // [R08] [R09]
            if (tb_we && rd[trig_pkg::ROAD_TRK_LSB +: 6] == tb_addr) begin
                n.pres[r][4] = 1'b1; // [R10]
            end
            if (hb_we && rd[int'(hb_addr[7:6]) * 6 +: 6] == hb_addr[5:0])
            begin
                n.pres[r][hb_addr[7:6]] = 1'b1; // [R10]
            end
        end
        // event time budget, counted from the first word
        if (!s.act && any_in && s.phase == trig_pkg::PH_COLLECT) begin
            n.act = 1'b1;
            n.cyc = '0;
            n.over = 1'b0;
        end else if (s.act) begin
            n.cyc = s.cyc + 9'h001;
            if (s.cyc == trig_pkg::BUDGET_CYC - 9'h001) begin
                n.over = 1'b1; // [R19]
            end
        end
        // event phases
        n.pv = 1'b0;
        case (s.phase)
            trig_pkg::PH_COLLECT: begin
                if (flush) begin
                    n.phase = trig_pkg::PH_DRAIN;
                end
            end
            trig_pkg::PH_DRAIN: begin
                if (s.cnt == '0 && !s.t2.valid) begin
                    n.phase = trig_pkg::PH_SCAN; // [R13]
                    n.road = '0;
                end
            end
            trig_pkg::PH_SCAN: begin
                rd = roads[s.road];
                if (&s.pres[s.road]) begin
                    x[4] = tbin[rd[trig_pkg::ROAD_TRK_LSB +: 6]]; // [R14]
                    for (int l = 0; l < 4; l++) begin
                        x[l] = hbin[{2'(l), rd[l * 6 +: 6]}]; // [R14]
                    end
                    n.pkt = x; // [R15]
                    // one scalar product per parameter: phi, pt, d
                    for (int k = 0; k < 3; k++) begin
                        acc = '0;
                        for (int i = 0; i < 5; i++) begin
                            acc = acc + 26'($signed({1'b0, x[i]})
                                  * $signed(trig_pkg::FIT_COEF[k][i])); // [R17]
                        end
                        n.fit[k * 16 +: 16] = acc[23:8]; // [R20]
                    end
                    n.pv = 1'b1;
                    n.proad = s.road;
                    n.osel = s.fsel;
                    n.fsel = (s.fsel == 4'(trig_pkg::NUM_FIT - 1))
                             ? 4'h0 : s.fsel + 4'h1; // [R16]
                end
                n.road = s.road + 7'h01;
                if (s.road == 7'(trig_pkg::NUM_ROADS - 1)) begin
                    n.phase = trig_pkg::PH_COLLECT;
                    n.pres = '0;
                    n.act = 1'b0;
                end
            end
            default: begin
                n.phase = trig_pkg::PH_COLLECT;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers and tables
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            s <= '0;
            s.shift <= trig_pkg::SS_SHIFT_RST;
        end else begin
            s <= n; // [R18]
        end
    end

    // tables are not cleared by reset; software loads them first
    always_ff @(posedge CORE_CLK) begin
        if (LOAD.we && LOAD.sel == trig_pkg::LD_PED) begin
            ped[LOAD.addr] <= LOAD.data[8:0];
        end
        if (LOAD.we && LOAD.sel == trig_pkg::LD_LUT) begin
            lut[LOAD.addr[7:0]] <= LOAD.data[5:0];
        end
        if (LOAD.we && LOAD.sel == trig_pkg::LD_ROAD) begin
            roads[LOAD.addr[6:0]] <= LOAD.data; // [R11]
        end
        if (hb_we) begin
            hbin[hb_addr] <= hb_data; // [R12]
        end
        if (tb_we) begin
            tbin[tb_addr] <= s.t2.data; // [R12]
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // hold as soon as one cluster waits: two sync flops are in flight
    for (genvar u = 0; u < 3; u++) begin : g_hold
        assign HOLD[u] = s.cnt[u] != 2'h0
                         || s.phase != trig_pkg::PH_COLLECT; // [R21]
    end
    assign PKT = s.pkt;
    assign PKT_VALID = s.pv;
    assign PKT_ROAD = s.proad;
    assign FIT_SEL = s.osel;
    assign FIT_PARAM = s.fit;
    assign OVER_BUDGET = s.over;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);

    logic [3:0] exp_sel;
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            exp_sel <= 4'h0;
        end else if (PKT_VALID) begin
            exp_sel <= (exp_sel == 4'h9) ? 4'h0 : exp_sel + 4'h1;
        end
    end

    property p_fit_rr;
        PKT_VALID |-> FIT_SEL == exp_sel;
    endproperty
    a_fit_rr: assert property (p_fit_rr) // [R16]
        else $error("fitter out of turn");
    property p_budget;
        s.act && s.cyc == trig_pkg::BUDGET_CYC - 9'h001 |=> OVER_BUDGET;
    endproperty
    a_budget: assert property (p_budget) // [R19]
        else $error("budget flag missing");
    property p_scan_end;
        s.phase == trig_pkg::PH_SCAN && s.road == 7'h7f
        |=> s.phase == trig_pkg::PH_COLLECT && s.pres == '0;
    endproperty
    a_scan_end: assert property (p_scan_end) // [R13]
        else $error("scan did not end");
    // hold must keep every cluster queue within its two entries
    property p_hold;
        s.cnt[0] != 2'h3 && s.cnt[1] != 2'h3 && s.cnt[2] != 2'h3;
    endproperty
    a_hold: assert property (p_hold) // [R21]
        else $error("cluster queue overflow");
    property p_match;
        s.phase == trig_pkg::PH_SCAN && &s.pres[s.road]
        |=> PKT_VALID && PKT_ROAD == $past(s.road);
    endproperty
    a_match: assert property (p_match) // [R10]
        else $error("candidate road not sent");
    property p_merge;
        s.cnt[1] != 2'h0 && !s.t2.valid
        && s.phase != trig_pkg::PH_SCAN |-> gv;
    endproperty
    a_merge: assert property (p_merge) // [R04]
        else $error("merger idle with pending cluster");
    property p_push;
        $past(STRIP_IN[0].valid, 2) && !$past(RESET)
        && !$past(RESET, 2) |-> s.sy2[0].valid;
    endproperty
    a_push: assert property (p_push) // [R05]
        else $error("pushed word not taken");
    property p_pkt_src;
        PKT_VALID |-> $past(s.phase) == trig_pkg::PH_SCAN;
    endproperty
    a_pkt_src: assert property (p_pkt_src) // [R15]
        else $error("packet outside scan");

    c_pkt: cover property (PKT_VALID ##1 PKT_VALID);
    c_over: cover property (OVER_BUDGET && s.phase == trig_pkg::PH_SCAN);
    c_hold: cover property (HOLD == 3'h0 ##1 HOLD[0]);

endmodule

`default_nettype wire

// ==== core/trig_pkg.sv ====
package trig_pkg;

    // ------------------------------------------------------------
    // sizes and timing
    // ------------------------------------------------------------
    localparam int NUM_ROADS  = 128;
    localparam int NUM_FIT    = 10;
    localparam int CLK_NS     = 50;
    localparam int BUDGET_NS  = 17000;
    // longest time, so the division rounds down
    localparam logic [8:0] BUDGET_CYC = 9'(BUDGET_NS / CLK_NS);

    // ------------------------------------------------------------
    // field positions, limits, reset values
    // ------------------------------------------------------------
    localparam logic [8:0] HIT_THRESH   = 9'h008;
    localparam logic [7:0] MAX_WIDTH    = 8'h03;
    localparam logic [3:0] SS_SHIFT_RST = 4'h6;
    localparam int         TRK_SS_LSB   = 8;
    localparam int         ROAD_TRK_LSB = 24;
    localparam logic [1:0] LD_PED   = 2'h0;
    localparam logic [1:0] LD_LUT   = 2'h1;
    localparam logic [1:0] LD_ROAD  = 2'h2;
    localparam logic [1:0] LD_SHIFT = 2'h3;
    // fit constants: [param][coordinate], coordinate 4 is the track
    localparam logic [2:0][4:0][7:0] FIT_COEF = {
        8'h10, 8'hf8, 8'h04, 8'h02, 8'h01,
        8'h01, 8'h02, 8'hfc, 8'h08, 8'h20,
        8'h08, 8'h08, 8'h08, 8'h08, 8'hf0};

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_COLLECT = 2'b00,
        PH_DRAIN   = 2'b01,
        PH_SCAN    = 2'b10
    } phase_t;
    typedef struct packed {
        logic       valid;
        logic       hdr;
        logic [7:0] data;
    } strip_word_t;
    typedef struct packed {
        logic        valid;
        logic [13:0] data;
    } trk_word_t;
    typedef struct packed {
        logic        we;
        logic [1:0]  sel;
        logic [9:0]  addr;
        logic [29:0] data;
    } load_t;
    typedef struct packed {
        logic [13:0]      trk;
        logic [3:0][13:0] hit;
    } packet_t;
    typedef struct packed {
        logic [15:0] phi;
        logic [15:0] pt;
        logic [15:0] d;
    } fit_t;

endpackage

// ==== testbench/strip_feed.sv ====
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// strip readout source: pushes queued words, stops on hold
// ----------------------------------------------------------------
module strip_feed (
    input  wire logic             clk,  // core clock
    input  wire logic             hold, // stop request from receiver
    output trig_pkg::strip_word_t word  // pushed word
);
    logic [8:0] q[$]; // {hdr, data}
    logic [8:0] w;

    // header word first, then channel/height pairs
    task automatic put(input logic [8:0] v);
        q.push_back(v);
    endtask

    function automatic int left();
        return q.size();
    endfunction

    initial word = '0;

    // no per-word request; obeys hold within one cycle
    always @(posedge clk) begin
        #1;
        if (q.size() != 0 && hold !== 1'b1) begin
            w = q.pop_front();
            word = {1'b1, w};
        end else begin
            // idle line shows inverted data so stale words never match
            word = {1'b0, word.hdr, ~word.data};
        end
    end
endmodule

`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb;
    localparam int P = 50;
    logic                  CORE_CLK;
    logic                  RESET;
    logic                  EVT_END;
    trig_pkg::strip_word_t w0, w1, w2;
    trig_pkg::trk_word_t   TRK_IN;
    trig_pkg::load_t       LOAD;
    logic [2:0]            HOLD;
    trig_pkg::packet_t     PKT;
    logic                  PKT_VALID;
    logic [6:0]            PKT_ROAD;
    logic [3:0]            FIT_SEL;
    trig_pkg::fit_t        FIT_PARAM;
    logic                  OVER_BUDGET;
    int                    errors;
    int                    checked;
    logic [128:0]          seen_q[$]; // {road, fitter, packet, fit}

    // ------------------------------------------------------------
    // design and sources
    // ------------------------------------------------------------
    track_trigger dut (
        .CORE_CLK(CORE_CLK), .RESET(RESET), .STRIP_IN({w2, w1, w0}),
        .TRK_IN(TRK_IN), .EVT_END(EVT_END), .LOAD(LOAD), .HOLD(HOLD),
        .PKT(PKT), .PKT_VALID(PKT_VALID), .PKT_ROAD(PKT_ROAD),
        .FIT_SEL(FIT_SEL), .FIT_PARAM(FIT_PARAM),
        .OVER_BUDGET(OVER_BUDGET));
    strip_feed src0 (.clk(CORE_CLK), .hold(HOLD[0]), .word(w0));
    strip_feed src1 (.clk(CORE_CLK), .hold(HOLD[1]), .word(w1));
    strip_feed src2 (.clk(CORE_CLK), .hold(HOLD[2]), .word(w2));

    initial begin
        CORE_CLK = 1'b0;
        forever #(P/2) CORE_CLK = ~CORE_CLK;
    end

    // packets have no backpressure: catch every strobe
    always @(posedge CORE_CLK) begin
        if (PKT_VALID === 1'b1)
            seen_q.push_back({PKT_ROAD, FIT_SEL, PKT, FIT_PARAM});
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [128:0] seen, input logic [128:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge CORE_CLK);
        #1;
    endtask

    task automatic ld(input logic [1:0] s, input logic [9:0] a,
                      input logic [29:0] d);
        tick(1);
        LOAD = {1'b1, s, a, d};
        tick(1);
        LOAD.we = 1'b0;
    endtask

    task automatic send(input int u, input logic h, input logic [7:0] d);
        case (u)
            0: src0.put({h, d});
            1: src1.put({h, d});
            default: src2.put({h, d});
        endcase
    endtask

    // strips 5 and 6 hit, pair at 20 closes the cluster
    task automatic cluster(input int u, input logic [7:0] chip,
                           input logic [7:0] h6);
        send(u, 1'b1, chip);
        send(u, 1'b0, 8'd5);
        send(u, 1'b0, 8'd200);
        send(u, 1'b0, 8'd6);
        send(u, 1'b0, h6);
        send(u, 1'b0, 8'd20);
        send(u, 1'b0, 8'd0);
    endtask

    // scalar products, param k in bits [16k+15:16k]
    function automatic trig_pkg::fit_t fit_of(trig_pkg::packet_t p);
        logic signed [31:0] acc;
        logic [4:0][13:0]   x;
        trig_pkg::fit_t     f;
        x = {p.trk, p.hit};
        for (int k = 0; k < 3; k++) begin
            acc = 0;
            for (int i = 0; i < 5; i++)
                acc += $signed(trig_pkg::FIT_COEF[k][i])
                       * $signed({18'h0, x[i]});
            f[16*k +: 16] = acc[23:8];
        end
        return f;
    endfunction

    // quiet gap, close event, sit out drain and scan
    task automatic evt_close();
        int n;
        n = 0;
        while (src0.left() + src1.left() + src2.left() != 0 && n < 300) begin
            tick(1);
            n++;
        end
        tick(4);
        EVT_END = 1'b1;
        tick(1);
        EVT_END = 1'b0;
        tick(4);
        check(HOLD, 3'h7);
        n = 0;
        while (HOLD !== 3'h0 && n < 600) begin
            tick(1);
            n++;
        end
        check(HOLD, 3'h0);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check({HOLD, PKT_VALID, OVER_BUDGET, FIT_SEL}, 0);
    endtask

    task automatic t_load();
        for (int u = 0; u < 3; u++) begin
            ld(trig_pkg::LD_PED, {u[1:0], 8'd5}, 30'h0);
            ld(trig_pkg::LD_PED, {u[1:0], 8'd6}, 30'h0);
            ld(trig_pkg::LD_PED, {u[1:0], 8'd20}, 30'h0);
        end
        for (int c = 0; c < 4; c++)
            ld(trig_pkg::LD_LUT, 10'(c * 8), 30'(c + 1));
        // roads 5 and 9 identical, the rest unreachable
        for (int r = 0; r < 128; r++)
            ld(trig_pkg::LD_ROAD, 10'(r), (r == 5 || r == 9) ?
               {6'd10, 6'd4, 6'd3, 6'd2, 6'd1} : 30'h3fffffff);
    endtask

    task automatic t_event(input bit full, input bit bad,
                           input logic [3:0] s0);
        trig_pkg::packet_t p;
        logic [8:0]        c3;
        // bad strip 5 and raised pedestal on strip 6 of the last chip
        ld(trig_pkg::LD_PED, {2'h2, 8'd5}, bad ? 30'h100 : 30'h0);
        ld(trig_pkg::LD_PED, {2'h2, 8'd6}, bad ? 30'd100 : 30'h0);
        seen_q.delete();
        tick(1);
        TRK_IN = {1'b1, 6'd10, 8'h2a};
        tick(1);
        TRK_IN.valid = 1'b0;
        cluster(0, 8'd0, 8'd200);
        cluster(0, 8'd1, 8'd200);
        cluster(1, 8'd2, 8'd200);
        if (full)
            cluster(2, 8'd3, bad ? 8'd108 : 8'd200);
        evt_close();
        c3 = bad ? 9'd12 : 9'd11;
        p = {6'd10, 8'h2a, 5'd3, c3, 5'd2, 9'd11, 5'd1, 9'd11, 5'd0, 9'd11};
        check(seen_q.size(), full ? 2 : 0);
        if (full && seen_q.size() == 2) begin
            check(seen_q[0], {7'd5, s0, p, fit_of(p)});
            check(seen_q[1], {7'd9, s0 + 4'd1, p, fit_of(p)});
        end
        check(OVER_BUDGET, 1'b0);
    endtask

    // open cluster closed by event end, five-strip cluster dropped
    task automatic t_flush();
        trig_pkg::packet_t p;
        for (int c = 7; c < 10; c++)
            ld(trig_pkg::LD_PED, {2'h2, 8'(c)}, 30'h0);
        seen_q.delete();
        tick(1);
        TRK_IN = {1'b1, 6'd10, 8'h2a};
        tick(1);
        TRK_IN.valid = 1'b0;
        cluster(1, 8'd1, 8'd200);
        cluster(1, 8'd2, 8'd200);
        cluster(2, 8'd3, 8'd200);
        // strips 5..9 would overwrite the layer 3 bin if kept
        send(2, 1'b1, 8'd3);
        for (int c = 5; c < 10; c++) begin
            send(2, 1'b0, 8'(c));
            send(2, 1'b0, 8'd200);
        end
        send(2, 1'b0, 8'd20);
        send(2, 1'b0, 8'd0);
        // strip 6 alone, left open until the event closes
        send(0, 1'b1, 8'd0);
        send(0, 1'b0, 8'd6);
        send(0, 1'b0, 8'd200);
        evt_close();
        p = {6'd10, 8'h2a, 5'd3, 9'd11, 5'd2, 9'd11, 5'd1, 9'd11, 5'd0, 9'd12};
        check(seen_q.size(), 2);
        if (seen_q.size() == 2) begin
            check(seen_q[0], {7'd5, 4'd6, p, fit_of(p)});
            check(seen_q[1], {7'd9, 4'd7, p, fit_of(p)});
        end
    endtask

    // coarser superstrips: index is centroid over 128
    task automatic t_shift();
        ld(trig_pkg::LD_SHIFT, 10'h0, 30'h7);
        for (int c = 0; c < 4; c++)
            ld(trig_pkg::LD_LUT, 10'(c * 4), 30'(c + 1));
        t_event(1'b1, 1'b0, 4'd4);
    endtask

    task automatic t_budget();
        send(0, 1'b1, 8'd0);
        tick(360);
        check(OVER_BUDGET, 1'b1);
        evt_close();
        send(0, 1'b1, 8'd0);
        tick(6);
        check(OVER_BUDGET, 1'b0);
        evt_close();
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        errors = 0;
        checked = 0;
        RESET = 1'b1;
        EVT_END = 1'b0;
        TRK_IN = '0;
        LOAD = '0;
        tick(2);
        RESET = 1'b0;
        t_reset();
        t_load();
        t_event(1'b1, 1'b0, 4'd0);
        t_event(1'b1, 1'b1, 4'd2);
        t_event(1'b0, 1'b0, 4'd0);
        t_shift();
        t_flush();
        t_budget();
        results();
    end

    // whole run needs about 2000 cycles
    initial begin
        #(P * 20000);
        errors++;
        results();
    end
endmodule

`default_nettype wire
